/* File: design/lsm_top.sv */
// logic supply monitor and shutdown: power-up sequence, window filter,
// overvoltage latch, threshold self-test and diagnostic mode selection
// assumes analog comparators on I_MON, register strobes from the spi logic on I_MCLK,
// and I_RST_B low while the logic supply is below the functional reset level
`timescale 1ns/1ns
`include "lsm_cfg.svh"

module lsm_top #(
  parameter int unsigned FIL_CYC = `LSM_FIL_CYC,
  parameter int unsigned POR_CYC = `LSM_POR_CYC
) (
  input wire logic I_MCLK,
  input wire logic I_RST_B,
  input wire lsm_pkg::lsm_mon_t I_MON,
  input wire logic I_REG_WR,
  input wire logic [7:0] I_REG_WDATA,
  output logic [7:0] O_REG_RDATA,
  output logic O_ABE_OUT,
  output logic O_ABE_OE,
  output logic O_STAGE_EN,
  output logic O_DIAG_LOG_EN,
  output logic O_SPI_MODE,
  output logic O_OV_TEST_THR,
  output logic O_UV_TEST_THR
);
  import lsm_pkg::*;

  localparam logic [`LSM_CNT_W-1:0] POR_LAST = `LSM_CNT_W'(POR_CYC - 1);

  lsm_top_st_t st_q;
  lsm_top_st_t st_d;
  lsm_mon_t mon_s;
  logic uv_f;
  logic ov_f;
  logic spi;
  logic fault;
  logic run_d;

  // ********************************************
  // helpers
  // ********************************************
  function automatic logic test_is(input lsm_ctrl_t c, input logic s, input logic [1:0] m);
    test_is = s && (c.test == m);
  endfunction

  function automatic lsm_ctrl_t ctrl_default();
    lsm_ctrl_t c;
    c.test = `LSM_RST_TEST;
    c.latch_en = `LSM_RST_LATCH_EN;
    ctrl_default = c;
  endfunction

  // ********************************************
  // input synchronisation and filtering
  // ********************************************
  lsm_sync u_sync (
    .i_clk(I_MCLK),
    .i_rst_b(I_RST_B),
    .i_mon(I_MON),
    .o_mon(mon_s)
  );

  // both directions use the same filter time
  lsm_filter #(
    .CYC(FIL_CYC)
  ) u_uv_filt (
    .i_clk(I_MCLK),
    .i_rst_b(I_RST_B),
    .i_raw(mon_s.under),
    .o_filt(uv_f)
  );

  lsm_filter #(
    .CYC(FIL_CYC)
  ) u_ov_filt (
    .i_clk(I_MCLK),
    .i_rst_b(I_RST_B),
    .i_raw(mon_s.over),
    .o_filt(ov_f)
  );

  assign spi = !mon_s.io_low;
  assign fault = uv_f || ov_f || st_q.ov_latch;

  // ********************************************
  // sequence, register and shutdown logic
  // ********************************************
  always_comb begin
    st_d = st_q;
    unique case (st_q.pwr)
      LSM_PWR_OFF: begin
        st_d.por_cnt = '0;
        if (mon_s.por_ok) begin
          st_d.pwr = LSM_PWR_WAIT;
        end
      end
      LSM_PWR_WAIT: begin
        if (st_q.por_cnt == POR_LAST) begin
          st_d.pwr = LSM_PWR_RUN;
          st_d.por_cnt = '0;
        end else begin
          st_d.por_cnt = st_q.por_cnt + `LSM_CNT_W'(1);
        end
      end
      LSM_PWR_RUN: begin
        st_d.por_cnt = '0;
      end
      default: begin
        st_d.pwr = LSM_PWR_OFF;
      end
    endcase
    if (!mon_s.por_ok) begin
      st_d.pwr = LSM_PWR_OFF;
      st_d.por_cnt = '0;
    end
    if (st_q.pwr != LSM_PWR_RUN) begin
      st_d.ctrl = ctrl_default();
      st_d.ov_latch = 1'b0;
    end else begin
      // writes are taken during a fault too
      if (spi && I_REG_WR) begin
        st_d.ctrl.test = I_REG_WDATA[`LSM_BIT_TEST_HI:`LSM_BIT_TEST_LO];
        st_d.ctrl.latch_en = I_REG_WDATA[`LSM_BIT_LATCH_EN];
        if (I_REG_WDATA[`LSM_BIT_LATCH_EN] != st_q.ctrl.latch_en) begin
          st_d.ov_latch = 1'b0;
        end
      end
      if (!spi) begin
        st_d.ctrl = ctrl_default();
        st_d.ov_latch = 1'b0;
      end else if (ov_f && st_q.ctrl.latch_en) begin
        st_d.ov_latch = 1'b1;
      end
    end
    run_d = (st_d.pwr == LSM_PWR_RUN);
    st_d.stage_en = run_d && !fault && mon_s.abe_hi;
    st_d.abe_oe = !run_d || fault;
    st_d.log_en = run_d && !fault;
    if (spi) begin
      st_d.rdata = `LSM_RD_IDLE;
      st_d.rdata[`LSM_BIT_TEST_HI:`LSM_BIT_TEST_LO] = st_q.ctrl.test;
      st_d.rdata[`LSM_BIT_OV_LATCHED] = st_q.ov_latch;
      st_d.rdata[`LSM_BIT_LATCH_EN] = st_q.ctrl.latch_en;
      st_d.rdata[`LSM_BIT_SUP_OK] = !fault;
      st_d.rdata[`LSM_BIT_UV_OK] = !uv_f;
      st_d.rdata[`LSM_BIT_OV_OK] = !ov_f;
    end else begin
      st_d.rdata = `LSM_RD_IDLE;
    end
  end

  // reset gives outputs off and the enable line driven low
  always_ff @(posedge I_MCLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      st_q.pwr <= LSM_PWR_OFF;
      st_q.por_cnt <= '0;
      st_q.ctrl.test <= `LSM_RST_TEST;
      st_q.ctrl.latch_en <= `LSM_RST_LATCH_EN;
      st_q.ov_latch <= 1'b0;
      st_q.stage_en <= 1'b0;
      st_q.abe_oe <= 1'b1;
      st_q.log_en <= 1'b0;
      st_q.rdata <= `LSM_RD_IDLE;
    end else begin
      st_q <= st_d;
    end
  end

  // ********************************************
  // outputs
  // ********************************************
  assign O_REG_RDATA = st_q.rdata;
  assign O_ABE_OUT = 1'b0;
  assign O_ABE_OE = st_q.abe_oe;
  assign O_STAGE_EN = st_q.stage_en;
  assign O_DIAG_LOG_EN = st_q.log_en;
  assign O_SPI_MODE = spi;
  assign O_OV_TEST_THR = test_is(st_q.ctrl, spi, `LSM_TEST_OV);
  assign O_UV_TEST_THR = test_is(st_q.ctrl, spi, `LSM_TEST_UV);

  // ********************************************
  // checks
  // ********************************************
  default clocking cb @(posedge I_MCLK);
  endclocking
  default disable iff (!I_RST_B);

  property p_por_off;
    !mon_s.por_ok |=> O_ABE_OE && !O_STAGE_EN && st_q.pwr == LSM_PWR_OFF;
  endproperty
  a_por_off: assert property (p_por_off) else $error("no shutdown below por");

  property p_por_wait;
    (st_q.pwr == LSM_PWR_WAIT && st_q.por_cnt != POR_LAST) |=> st_q.pwr != LSM_PWR_RUN;
  endproperty
  a_por_wait: assert property (p_por_wait) else $error("run before por delay");

  property p_fault_abe;
    fault |=> O_ABE_OE && !O_ABE_OUT && !O_STAGE_EN;
  endproperty
  a_fault_abe: assert property (p_fault_abe) else $error("fault left stages on");

  property p_ext_abe;
    !mon_s.abe_hi |=> !O_STAGE_EN;
  endproperty
  a_ext_abe: assert property (p_ext_abe) else $error("external disable ignored");

  property p_release;
    (st_q.pwr == LSM_PWR_RUN && mon_s.por_ok && !fault) |=> !O_ABE_OE && O_DIAG_LOG_EN;
  endproperty
  a_release: assert property (p_release) else $error("enable not released");

  property p_no_log;
    fault |=> !O_DIAG_LOG_EN;
  endproperty
  a_no_log: assert property (p_no_log) else $error("logging during fault");

  property p_latch_hold;
    (st_q.ov_latch && !I_REG_WR && spi && mon_s.por_ok && st_q.pwr == LSM_PWR_RUN)
      |=> st_q.ov_latch ##1 O_ABE_OE;
  endproperty
  a_latch_hold: assert property (p_latch_hold) else $error("latch dropped");

  property p_flag_mode;
    !spi |=> !O_OV_TEST_THR && !O_UV_TEST_THR && !st_q.ov_latch && O_REG_RDATA == 8'h00;
  endproperty
  a_flag_mode: assert property (p_flag_mode) else $error("flag mode not enforced");

  property p_ov_test;
    (I_REG_WR && spi && mon_s.por_ok && st_q.pwr == LSM_PWR_RUN
      && I_REG_WDATA[7:6] == 2'h0) |=> O_OV_TEST_THR || !O_SPI_MODE;
  endproperty
  a_ov_test: assert property (p_ov_test) else $error("ov test not selected");

  property p_uv_test;
    (I_REG_WR && spi && mon_s.por_ok && st_q.pwr == LSM_PWR_RUN
      && I_REG_WDATA[7:6] == 2'h1) |=> O_UV_TEST_THR || !O_SPI_MODE;
  endproperty
  a_uv_test: assert property (p_uv_test) else $error("uv test not selected");

  property p_defaults;
    (st_q.pwr != LSM_PWR_RUN) |=> $past(st_q.pwr) != LSM_PWR_RUN
      && st_q.ctrl == ctrl_default() || st_q.pwr == LSM_PWR_RUN;
  endproperty
  a_defaults: assert property (p_defaults) else $error("registers not default");

  property p_stage_run;
    O_STAGE_EN |-> st_q.pwr == LSM_PWR_RUN;
  endproperty
  a_stage_run: assert property (p_stage_run) else $error("stages on outside run");

  property p_stage_resume;
    $rose(O_STAGE_EN) |-> $past(mon_s.abe_hi) && !$past(fault);
  endproperty
  a_stage_resume: assert property (p_stage_resume) else $error("stages on too early");

  property p_mon_bits;
    spi |=> O_REG_RDATA[`LSM_BIT_UV_OK] == !$past(uv_f)
      && O_REG_RDATA[`LSM_BIT_OV_OK] == !$past(ov_f);
  endproperty
  a_mon_bits: assert property (p_mon_bits) else $error("monitor bits wrong");

  property p_latch_set;
    (ov_f && st_q.ctrl.latch_en && spi && st_q.pwr == LSM_PWR_RUN && mon_s.por_ok)
      |=> st_q.ov_latch;
  endproperty
  a_latch_set: assert property (p_latch_set) else $error("latch not set");

  property p_no_latch;
    (!st_q.ctrl.latch_en && !st_q.ov_latch) |=> !st_q.ov_latch;
  endproperty
  a_no_latch: assert property (p_no_latch) else $error("latch set while disabled");

  property p_ov_off;
    $rose(ov_f) |=> O_ABE_OE && !O_DIAG_LOG_EN && !O_STAGE_EN;
  endproperty
  a_ov_off: assert property (p_ov_off) else $error("overvoltage not shut off");

  property p_uv_off;
    $rose(uv_f) |=> O_ABE_OE && !O_DIAG_LOG_EN && !O_STAGE_EN;
  endproperty
  a_uv_off: assert property (p_uv_off) else $error("undervoltage not shut off");

  c_run: cover property ($rose(O_STAGE_EN));
  c_latch: cover property ($rose(st_q.ov_latch));
  c_ov_test: cover property (O_OV_TEST_THR && !O_REG_RDATA[0]);
  c_flag: cover property ($fell(O_SPI_MODE));

endmodule

/* File: include/lsm_cfg.svh */
// constants of the logic supply monitor: timing, register bit positions, reset values
// assumes a 125 MHz logic clock; included by the package and by the lsm_top and lsm_filter design files
`ifndef LSM_CFG_SVH
`define LSM_CFG_SVH

// ********************************************
// timing
// ********************************************
`define LSM_CLK_PERIOD_NS 8
`define LSM_FIL_TIME_US 100
`define LSM_FIL_MIN_US 60
`define LSM_FIL_MAX_US 135
`define LSM_FIL_CYC ((`LSM_FIL_TIME_US * 1000) / `LSM_CLK_PERIOD_NS)
`define LSM_POR_TIME_US 220
`define LSM_POR_CYC ((`LSM_POR_TIME_US * 1000) / `LSM_CLK_PERIOD_NS)
`define LSM_CNT_W 16

// ********************************************
// status/control register layout
// ********************************************
`define LSM_BIT_OV_OK 0
`define LSM_BIT_UV_OK 1
`define LSM_BIT_SUP_OK 2
`define LSM_BIT_LATCH_EN 3
`define LSM_BIT_OV_LATCHED 4
`define LSM_BIT_TEST_LO 6
`define LSM_BIT_TEST_HI 7
`define LSM_TEST_OV 2'h0
`define LSM_TEST_UV 2'h1
`define LSM_RST_TEST 2'h2
`define LSM_RST_LATCH_EN 1'h0
`define LSM_RD_IDLE 8'h00

`endif

/* File: include/lsm_pkg.sv */
// types of the logic supply monitor
// assumes lsm_cfg.svh is on the include path
`include "lsm_cfg.svh"

package lsm_pkg;

  // power sequence, gray along off -> wait -> run
  typedef enum logic [1:0] {
    LSM_PWR_OFF  = 2'h0,
    LSM_PWR_WAIT = 2'h1,
    LSM_PWR_RUN  = 2'h3
  } lsm_pwr_t;

  // comparator and pin levels coming from outside the clock domain
  typedef struct packed {
    logic abe_hi;
    logic io_low;
    logic por_ok;
    logic under;
    logic over;
  } lsm_mon_t;

  typedef struct packed {
    logic [1:0] test;
    logic latch_en;
  } lsm_ctrl_t;

  typedef struct packed {
    lsm_mon_t s1;
    lsm_mon_t s2;
  } lsm_sync_st_t;

  typedef struct packed {
    logic filt;
    logic [`LSM_CNT_W-1:0] cnt;
  } lsm_filt_st_t;

  typedef struct packed {
    lsm_pwr_t pwr;
    logic [`LSM_CNT_W-1:0] por_cnt;
    lsm_ctrl_t ctrl;
    logic ov_latch;
    logic stage_en;
    logic abe_oe;
    logic log_en;
    logic [7:0] rdata;
  } lsm_top_st_t;

endpackage

/* File: design/lsm_sync.sv */
// two-stage synchroniser for the monitor comparators and the enable pin
// assumes asynchronous inputs and an active-low asynchronous reset
`timescale 1ns/1ns

module lsm_sync (
  input wire logic i_clk,
  input wire logic i_rst_b,
  input wire lsm_pkg::lsm_mon_t i_mon,
  output lsm_pkg::lsm_mon_t o_mon
);
  import lsm_pkg::*;

  lsm_sync_st_t st_q;
  lsm_sync_st_t st_d;

  always_comb begin
    st_d.s1 = i_mon;
    st_d.s2 = st_q.s1;
  end

  // reset value: supply low, no fault, enable pin low
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign o_mon = st_q.s2;

endmodule

/* File: design/lsm_filter.sv */
// glitch filter for one supply comparator
// assumes a synchronised input on the same clock
`timescale 1ns/1ns
`include "lsm_cfg.svh"

module lsm_filter #(
  parameter int unsigned CYC = `LSM_FIL_CYC
) (
  input wire logic i_clk,
  input wire logic i_rst_b,
  input wire logic i_raw,
  output logic o_filt
);
  import lsm_pkg::*;

  localparam logic [`LSM_CNT_W-1:0] LAST = `LSM_CNT_W'(CYC - 1);

  lsm_filt_st_t st_q;
  lsm_filt_st_t st_d;

  always_comb begin
    st_d = st_q;
    if (i_raw == st_q.filt) begin
      st_d.cnt = '0;
    end else if (st_q.cnt == LAST) begin
      st_d.filt = i_raw;
      st_d.cnt = '0;
    end else begin
      st_d.cnt = st_q.cnt + `LSM_CNT_W'(1);
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign o_filt = st_q.filt;

  // ********************************************
  // checks
  // ********************************************
  property p_filt_time;
    @(posedge i_clk) disable iff (!i_rst_b)
    $changed(st_q.filt) |-> $past(st_q.cnt) == LAST && $past(i_raw) == st_q.filt;
  endproperty
  a_filt_time: assert property (p_filt_time) else $error("filter moved early");

  property p_filt_restart;
    @(posedge i_clk) disable iff (!i_rst_b)
    (i_raw == st_q.filt) |=> st_q.cnt == '0 && $stable(st_q.filt);
  endproperty
  a_filt_restart: assert property (p_filt_restart) else $error("filter not restarted");

endmodule

/* File: sim/lsm_host_model.sv */
// microcontroller side of the bridge enable line
// assumes the device only ever pulls the line low, never drives it high
`timescale 1ns/1ns

module lsm_host_model (
  input wire logic i_dev_oe,
  input wire logic i_pull_low,
  input wire logic i_short_hi,
  output logic o_abe_hi
);
  // ********************************************
  // line level
  // ********************************************
  // line is high unless the host or the device pulls it low; a short to supply overrides everyone
  assign o_abe_hi = i_short_hi | ~(i_dev_oe | i_pull_low);
endmodule

/* File: sim/tb_top.sv */
// self-checking bench for the logic supply monitor
// assumes short filter and reset counts, host model on the enable line
`timescale 1ns/1ns

module tb_top;
  import lsm_pkg::*;
  localparam int unsigned FCYC = 8;
  localparam int unsigned PCYC = 16;
  logic I_MCLK = 1'b0;
  logic I_RST_B = 1'b0;
  logic I_REG_WR = 1'b0;
  logic [7:0] I_REG_WDATA = 8'h00;
  logic [7:0] O_REG_RDATA;
  logic O_ABE_OUT, O_ABE_OE, O_STAGE_EN, O_DIAG_LOG_EN, O_SPI_MODE;
  logic O_OV_TEST_THR, O_UV_TEST_THR;
  logic io_low = 1'b0;
  logic por_ok = 1'b1;
  logic uv = 1'b0;
  logic ov = 1'b0;
  logic pull_low = 1'b0;
  logic short_hi = 1'b0;
  logic abe_hi;
  lsm_mon_t I_MON;
  logic [13:0] obs;
  logic [27:0] q[$];
  int error_cnt = 0;
  int compares = 0;
  logic [31:0] rnd = 32'h895AD047;
  event chk_ev;

  // ********************************************
  // clock, comparators, instances
  // ********************************************
  always #4 I_MCLK = ~I_MCLK;
  // comparators see the nominal supply as out of range once a test threshold is selected
  assign I_MON = {abe_hi, io_low, por_ok, uv | O_UV_TEST_THR, ov | O_OV_TEST_THR};
  assign obs = {O_REG_RDATA, O_ABE_OE, O_STAGE_EN, O_DIAG_LOG_EN, O_SPI_MODE,
    O_OV_TEST_THR, O_UV_TEST_THR};

  lsm_top #(.FIL_CYC(FCYC), .POR_CYC(PCYC)) lsm_top_inst (
    .I_MCLK(I_MCLK), .I_RST_B(I_RST_B), .I_MON(I_MON), .I_REG_WR(I_REG_WR),
    .I_REG_WDATA(I_REG_WDATA), .O_REG_RDATA(O_REG_RDATA), .O_ABE_OUT(O_ABE_OUT),
    .O_ABE_OE(O_ABE_OE), .O_STAGE_EN(O_STAGE_EN), .O_DIAG_LOG_EN(O_DIAG_LOG_EN),
    .O_SPI_MODE(O_SPI_MODE), .O_OV_TEST_THR(O_OV_TEST_THR),
    .O_UV_TEST_THR(O_UV_TEST_THR));
  lsm_host_model lsm_host_model_inst (.i_dev_oe(O_ABE_OE), .i_pull_low(pull_low),
    .i_short_hi(short_hi), .o_abe_hi(abe_hi));

  // ********************************************
  // tasks
  // ********************************************
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction

  task automatic give_verdict();
    $display("compares %0d error_cnt %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge I_MCLK);
    #1;
  endtask

  task automatic check(input logic [13:0] seen, input logic [13:0] exp);
    compares++;
    if (seen !== exp) begin
      error_cnt++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic note(input logic [13:0] msk, input logic [13:0] exp);
    q.push_back({msk, exp});
    -> chk_ev;
  endtask

  // watcher: drains the notes oldest first against the outputs
  always @(chk_ev) begin
    while (q.size() > 0) begin
      check(obs & q[0][27:14], q[0][13:0]);
      check({13'h0000, O_ABE_OUT}, 14'h0000);
      void'(q.pop_front());
    end
  end

  task automatic wait_obs(input int b, input logic v);
    int n;
    n = 0;
    while (obs[b] !== v && n < 200) begin
      tick(1);
      n++;
    end
    if (n == 200) begin
      error_cnt++;
      $display("Error at %0t: wait seen %h expected %h", $time, obs[b], v);
      give_verdict();
    end
    tick(3);
  endtask

  task automatic wr(input logic [7:0] d);
    I_REG_WR = 1'b1;
    I_REG_WDATA = d;
    tick(1);
    I_REG_WR = 1'b0;
    tick(3);
  endtask

  // ********************************************
  // scenarios
  // ********************************************
  initial begin
    tick(5);
    note(14'h3FFF, {8'h00, 6'b100100});
    I_RST_B = 1'b1;
    tick(PCYC / 2);
    note(14'h0010, 14'h0000);
    wait_obs(4, 1'b1);
    note(14'h3FFF, {8'h87, 6'b011100});
    $display("test power-up done");
    for (int i = 0; i < 4; i++) begin
      rnd = xs(rnd);
      uv = 1'b1;
      tick(1 + rnd[1:0]);
      uv = 1'b0;
      tick(2);
    end
    tick(FCYC + 4);
    note(14'h0030, 14'h0010);
    uv = 1'b1;
    short_hi = 1'b1;
    tick(FCYC);
    note(14'h0010, 14'h0010);
    wait_obs(5, 1'b1);
    note(14'h3FFF, {8'h81, 6'b100100});
    wr(8'h88);
    note(14'h3FFF, {8'h89, 6'b100100});
    uv = 1'b0;
    short_hi = 1'b0;
    tick(FCYC);
    note(14'h0010, 14'h0000);
    wait_obs(5, 1'b0);
    note(14'h3FFF, {8'h8F, 6'b011100});
    $display("test undervoltage done");
    ov = 1'b1;
    wait_obs(5, 1'b1);
    ov = 1'b0;
    tick(3 * FCYC);
    note(14'h3FFF, {8'h9B, 6'b100100});
    wr(8'h80);
    wait_obs(5, 1'b0);
    note(14'h3FFF, {8'h87, 6'b011100});
    ov = 1'b1;
    wait_obs(5, 1'b1);
    note(14'h0030, 14'h0020);
    ov = 1'b0;
    wait_obs(5, 1'b0);
    wr(8'h80);
    note(14'h3FFF, {8'h87, 6'b011100});
    $display("test overvoltage done");
    for (int m = 0; m < 2; m++) begin
      rnd = xs(rnd);
      wr({m[1:0], rnd[5:0] & 6'h37});
      wait_obs(5, 1'b1);
      note(14'h31C3, {(m == 1) ? 8'h41 : 8'h02, 4'h0, m == 0, m == 1});
      wr(8'h80 | (rnd[7:0] & 8'h37));
      wait_obs(5, 1'b0);
      note(14'h3FFF, {8'h87, 6'b011100});
    end
    $display("test threshold self-test done");
    pull_low = 1'b1;
    wait_obs(4, 1'b0);
    note(14'h0030, 14'h0000);
    pull_low = 1'b0;
    wait_obs(4, 1'b1);
    $display("test external disable done");
    wr(8'h88);
    por_ok = 1'b0;
    tick(4);
    note(14'h0030, 14'h0020);
    por_ok = 1'b1;
    wait_obs(4, 1'b1);
    note(14'h3FFF, {8'h87, 6'b011100});
    $display("test power-on reset done");
    io_low = 1'b1;
    tick(4);
    note(14'h3FFF, {8'h00, 6'b011000});
    wr(8'h08);
    note(14'h3FC2, 14'h0000);
    uv = 1'b1;
    wait_obs(5, 1'b1);
    uv = 1'b0;
    wait_obs(5, 1'b0);
    io_low = 1'b0;
    tick(4);
    note(14'h0004, 14'h0004);
    $display("test flag mode done");
    give_verdict();
  end
endmodule
